/* hdl/perf_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          performance counter block.
// Assumes: Byte-wide register port; 100 MHz mclk.
// Notes:   Definitions only.
`ifndef PERF_DEFS_SVH
`define PERF_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define VIOL_HIGH_OFS     8'h00
`define VIOL_LOW_OFS      8'h01
`define CRC_HIGH_OFS      8'h02
`define CRC_LOW_OFS       8'h03
`define FAR_HIGH_OFS      8'h04
`define FAR_LOW_OFS       8'h05
`define MASK_TWO_OFS      8'h17

// ----------------------------------------------------------------------
// Fields, widths and reset values
// ----------------------------------------------------------------------
`define VIOL_W            16
`define CRC_W             10
`define FAR_W             10
`define ALIGN_W           12
`define ALIGN_SPLIT       6
`define SEC_MASK_BIT      4
`define MASK_TWO_RST      8'h00
`define UNMAPPED_DATA     8'h00
`define MF_FRAME_A        4'hD
`define MF_FRAME_B        4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MCLK_PERIOD_NS    10
`define LONG_PERIOD_US    1000000
`define SHORT_PERIOD_US   62500
`define LONG_CYCLES  ((`LONG_PERIOD_US * 1000) / `MCLK_PERIOD_NS)
`define SHORT_CYCLES ((`SHORT_PERIOD_US * 1000) / `MCLK_PERIOD_NS)

`endif

/* hdl/perf_pkg.sv */
// Purpose: Shared types of the performance counter block.
// Assumes: Nothing beyond the defs header.
// Notes:   Widths follow the counter sizes.
package perf_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] viol_t;
  typedef logic [9:0]  word_err_t;
  typedef logic [11:0] align_t;
  typedef logic [31:0] tmr_t;
endpackage

/* hdl/interval_counter.sv */
// Purpose: One counter that runs over an interval and is latched at its end.
// Assumes: boundary and inc come from mclk logic.
// Notes:   SAT chooses saturation at all ones instead of wrapping.
`timescale 1ns/1ps
`default_nettype none
module interval_counter #(
  parameter int unsigned W   = 10,
  parameter bit          SAT = 1'b0
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Events.
  input  wire logic         inc,
  input  wire logic         boundary,
  // Latched count of the last interval.
  output logic [W-1:0]      count
);
  logic [W-1:0] run_reg;
  logic [W-1:0] run_next;
  logic [W-1:0] held_reg;

  // An event in the boundary cycle still belongs to the closing interval.
  always_comb begin
    run_next = run_reg;
    if (inc && !(SAT && (&run_reg))) begin
      run_next = run_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Running count restarts from zero as the total is latched.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg  <= '0;
      held_reg <= '0;
    end else if (boundary) begin
      held_reg <= run_next;
      run_reg  <= '0;
    end else begin
      run_reg  <= run_next;
    end
  end

  assign count = held_reg;
endmodule // interval_counter
`default_nettype wire

/* hdl/e1_performance_error_counters.sv */
// Purpose: Receive-side performance counters of an E1 transceiver with
//          their byte-wide register port.
// Assumes: Line bits, framer flags and control bits come from mclk logic;
//          the register port pins are asynchronous to mclk.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - All four counts latch each second, or each 62.5 ms when selected.
// - Violation count is 16 bits, high byte at 00, low at 01.
// - Violation mode 0 counts marks repeating the previous mark polarity.
// - In mode 0 with HDB3 decoding on, substitution code word violations are skipped.
// - Violation mode 1 counts violations sharing the previous one's polarity.
// - Violation counting never stops, even without frame or multiframe sync.
// - Violation count saturates at 65,535 and never wraps.
// - CRC4 count is 10 bits: bits 9..8 at 02[1:0], bits 7..0 at 03.
// - CRC4 and E-bit counts halt on frame or CRC4 multiframe sync loss.
// - E-bit count takes the first bit of frames 13 and 15.
// - E-bit count adds one for each received E-bit of zero.
// - E-bit count is 10 bits: bits 9..8 at 04[1:0], bits 7..0 at 05.
// - Alignment count is 12 bits; its upper six bits sit at 02[7:2].
// - Alignment count lower six bits sit at 04[7:2].
// - Alignment count tallies errored words; halts only on frame sync loss.
// - CRC4, E-bit and alignment counts wrap freely; no saturation needed.
// - Mask bit 4 at 17 enables the one-second timer interrupt when set.
`timescale 1ns/1ps
`default_nettype none
`include "perf_defs.svh"
module e1_performance_error_counters #(
  parameter int unsigned LONG_CYCLES  = `LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = `SHORT_CYCLES
) (
  // Clock and reset.
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // Received line bits, one strobe per bit.
  input  wire logic           rx_bit_stb,
  input  wire logic           rx_pos,
  input  wire logic           rx_neg,
  // Framer events and sync state.
  input  wire logic           align_word_err,
  input  wire logic           crc_word_err,
  input  wire logic           ebit_stb,
  input  wire logic [3:0]     ebit_frame,
  input  wire logic           ebit_value,
  input  wire logic           frame_sync_lost,
  input  wire logic           crc_mf_sync_lost,
  input  wire logic           cas_mf_sync_lost,
  // Control bits held elsewhere.
  input  wire logic           period_short,
  input  wire logic           code_viol_mode,
  input  wire logic           hdb3_enable,
  // Register port pins.
  input  wire logic           port_cs_n,
  input  wire logic           port_rd_n,
  input  wire logic           port_wr_n,
  input  wire perf_pkg::byte_t port_addr,
  input  wire perf_pkg::byte_t port_data_in,
  output perf_pkg::byte_t     port_data_out,
  output logic                port_data_oe,
  // Timer event.
  output logic                timer_tick,
  output logic                timer_irq
);
  import perf_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Release is synchronised; assertion stays asynchronous.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------------
  tmr_t tmr_reg;
  tmr_t tmr_limit;
  logic tick_reg;

  assign tmr_limit = period_short ? tmr_t'(SHORT_CYCLES - 1)
                                  : tmr_t'(LONG_CYCLES - 1);

  // A change of period takes effect at once; a count past the new limit
  // restarts from zero with a tick on the next clock rather than stalling.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tmr_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (tmr_reg >= tmr_limit) begin
      tmr_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      tmr_reg  <= tmr_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  assign timer_tick = tick_reg;

  // ----------------------------------------------------------------------
  // Violation detection
  // ----------------------------------------------------------------------
  logic       have_mark_reg;
  logic       mark_pol_reg;
  logic [2:0] zero_run_reg;
  logic       have_bpv_reg;
  logic       bpv_pol_reg;
  logic       mark;
  logic       bpv;
  logic       sub_word;
  logic       code_viol;
  logic       viol_inc;

  assign mark = rx_pos | rx_neg;

  // A mark whose polarity repeats the previous mark.
  assign bpv = rx_bit_stb & mark & have_mark_reg
             & (rx_pos == mark_pol_reg);

  // 000V follows three zeros, B00V two; both are legal HDB3 words.
  assign sub_word = (zero_run_reg == 3'h2) || (zero_run_reg == 3'h3);

  // Successive violations of one polarity are code violations.
  assign code_viol = bpv & have_bpv_reg & (rx_pos == bpv_pol_reg);

  // No sync input is looked at here, so counting never pauses.
  assign viol_inc = code_viol_mode ? code_viol
                  : (bpv & ~(hdb3_enable & sub_word));

  // Polarity history and zero run length, saturating at four.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      have_mark_reg <= 1'b0;
      mark_pol_reg  <= 1'b0;
      zero_run_reg  <= 3'h0;
    end else if (rx_bit_stb) begin
      if (mark) begin
        have_mark_reg <= 1'b1;
        mark_pol_reg  <= rx_pos;
        zero_run_reg  <= 3'h0;
      end else if (zero_run_reg != 3'h4) begin
        zero_run_reg  <= zero_run_reg + 3'h1;
      end
    end
  end

  // Polarity of the last violation seen.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      have_bpv_reg <= 1'b0;
      bpv_pol_reg  <= 1'b0;
    end else if (bpv) begin
      have_bpv_reg <= 1'b1;
      bpv_pol_reg  <= rx_pos;
    end
  end

  // ----------------------------------------------------------------------
  // Framer event qualification
  // ----------------------------------------------------------------------
  logic crc_inc;
  logic far_inc;
  logic align_inc;
  logic mf_ok;
  logic ebit_slot;

  // CAS multiframe loss deliberately plays no part in any gate.
  assign mf_ok = ~frame_sync_lost & ~crc_mf_sync_lost;

  assign ebit_slot = (ebit_frame == `MF_FRAME_A)
                   || (ebit_frame == `MF_FRAME_B);

  assign crc_inc   = crc_word_err & mf_ok;
  assign far_inc   = ebit_stb & ebit_slot & ~ebit_value & mf_ok;
  assign align_inc = align_word_err & ~frame_sync_lost;

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  viol_t     viol_count;
  word_err_t crc_count;
  word_err_t far_count;
  align_t    align_count;

  // Only the violation counter can overrun within a second.
  interval_counter #(.W(`VIOL_W), .SAT(1'b1)) u_viol (
    .mclk     (mclk),
    .rst_n    (rst_sync_reg),
    .inc      (viol_inc),
    .boundary (tick_reg),
    .count    (viol_count)
  );

  // At most 1000 per second, so a 10-bit wrap never occurs.
  interval_counter #(.W(`CRC_W), .SAT(1'b0)) u_crc (
    .mclk     (mclk),
    .rst_n    (rst_sync_reg),
    .inc      (crc_inc),
    .boundary (tick_reg),
    .count    (crc_count)
  );

  // Far-end block errors, also bounded by 1000 per second.
  interval_counter #(.W(`FAR_W), .SAT(1'b0)) u_far (
    .mclk     (mclk),
    .rst_n    (rst_sync_reg),
    .inc      (far_inc),
    .boundary (tick_reg),
    .count    (far_count)
  );

  // Alignment word errors, bounded by 4000 per second.
  interval_counter #(.W(`ALIGN_W), .SAT(1'b0)) u_align (
    .mclk     (mclk),
    .rst_n    (rst_sync_reg),
    .inc      (align_inc),
    .boundary (tick_reg),
    .count    (align_count)
  );

  // ----------------------------------------------------------------------
  // Register port input synchronisers
  // ----------------------------------------------------------------------
  logic  cs_meta_reg;
  logic  cs_reg;
  logic  rd_meta_reg;
  logic  rd_reg;
  logic  wr_meta_reg;
  logic  wr_reg;
  logic  wr_dly_reg;
  byte_t addr_meta_reg;
  byte_t addr_reg;
  byte_t din_meta_reg;
  byte_t din_reg;

  // Strobes are active-low pins; copies here are active high.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cs_meta_reg <= 1'b0;
      cs_reg      <= 1'b0;
      rd_meta_reg <= 1'b0;
      rd_reg      <= 1'b0;
      wr_meta_reg <= 1'b0;
      wr_reg      <= 1'b0;
      wr_dly_reg  <= 1'b0;
    end else begin
      cs_meta_reg <= ~port_cs_n;
      cs_reg      <= cs_meta_reg;
      rd_meta_reg <= ~port_rd_n;
      rd_reg      <= rd_meta_reg;
      wr_meta_reg <= ~port_wr_n & ~port_cs_n;
      wr_reg      <= wr_meta_reg;
      wr_dly_reg  <= wr_reg;
    end
  end

  // Address and data are stable across a strobe, so plain two-stage
  // capture is enough; writes use the values sampled on the first clock after the write strobe ends.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      addr_meta_reg <= 8'h00;
      addr_reg      <= 8'h00;
      din_meta_reg  <= 8'h00;
      din_reg       <= 8'h00;
    end else begin
      addr_meta_reg <= port_addr;
      addr_reg      <= addr_meta_reg;
      din_meta_reg  <= port_data_in;
      din_reg       <= din_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Writable mask register
  // ----------------------------------------------------------------------
  byte_t mask_two_reg;
  logic  wr_done;

  // Writes land when the write strobe ends, with data fully settled.
  assign wr_done = wr_dly_reg & ~wr_reg;

  // Other bits are kept as storage for units outside this block.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mask_two_reg <= `MASK_TWO_RST;
    end else if (wr_done && (addr_reg == `MASK_TWO_OFS)) begin
      mask_two_reg <= din_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Timer interrupt
  // ----------------------------------------------------------------------
  logic irq_reg;

  // One-cycle pulse per boundary, passed only while the mask bit is one.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= tick_reg & mask_two_reg[`SEC_MASK_BIT];
    end
  end

  assign timer_irq = irq_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  byte_t rd_mux;
  byte_t dout_reg;
  logic  oe_reg;

  // Byte packing of the counts; unmapped offsets read as zero.
  always_comb begin
    case (addr_reg)
      `VIOL_HIGH_OFS: rd_mux = viol_count[15:8];
      `VIOL_LOW_OFS:  rd_mux = viol_count[7:0];
      `CRC_HIGH_OFS:  rd_mux = {align_count[11:`ALIGN_SPLIT],
                                crc_count[9:8]};
      `CRC_LOW_OFS:   rd_mux = crc_count[7:0];
      `FAR_HIGH_OFS:  rd_mux = {align_count[`ALIGN_SPLIT-1:0],
                                far_count[9:8]};
      `FAR_LOW_OFS:   rd_mux = far_count[7:0];
      `MASK_TWO_OFS:  rd_mux = mask_two_reg;
      default:        rd_mux = `UNMAPPED_DATA;
    endcase
  end

  // Latched counts only change at boundaries, so software that reads
  // within one interval sees a coherent set; a read straddling a
  // boundary may mix two intervals.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dout_reg <= 8'h00;
      oe_reg   <= 1'b0;
    end else begin
      dout_reg <= rd_mux;
      oe_reg   <= cs_reg & rd_reg;
    end
  end

  assign port_data_out = dout_reg;
  assign port_data_oe  = oe_reg;

  // ----------------------------------------------------------------------
  // Unused inputs
  // ----------------------------------------------------------------------
  logic unused_ok;

  // CAS multiframe state is accepted but has no effect on any count.
  assign unused_ok = cas_mf_sync_lost;

endmodule // e1_performance_error_counters
`default_nettype wire

/* testbench/perf_chk.sv */
// Purpose: Port checker of the performance counter block.
// Assumes: Reads hold address and strobes six cycles or more.
// Notes:   Bound into the top module after the module.
`timescale 1ns/1ps
`default_nettype none
`include "perf_defs.svh"
module perf_chk #(
  parameter int unsigned LONG_CYCLES  = 64,
  parameter int unsigned SHORT_CYCLES = 16
) (
  // Clock, reset and period select.
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic            period_short,
  // Register port and timer outputs.
  input wire logic            port_cs_n,
  input wire logic            port_rd_n,
  input wire perf_pkg::byte_t port_addr,
  input wire perf_pkg::byte_t port_data_out,
  input wire logic            port_data_oe,
  input wire logic            timer_tick,
  input wire logic            timer_irq
);
  import perf_pkg::*;
  logic [31:0] gap_reg;
  logic [31:0] lim;
  logic        chg_reg;
  logic        per_reg;
  logic        chg;
  logic [3:0]  quiet_reg;
  byte_t       addr_reg;
  // A period change voids one spacing check, so it cannot misfire.
  assign chg = chg_reg | (per_reg ^ period_short);
  assign lim = period_short ? SHORT_CYCLES : LONG_CYCLES;
  // Cycles since the last tick.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 32'h0;
      chg_reg <= 1'b1;
      per_reg <= 1'b0;
    end else begin
      gap_reg <= timer_tick ? 32'h1 : gap_reg + 32'h1;
      chg_reg <= (per_reg ^ period_short) | (chg_reg & !timer_tick);
      per_reg <= period_short;
    end
  end
  // Cycles with the read address unchanged and both strobes low.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg <= 4'h0;
      addr_reg  <= 8'h00;
    end else begin
      addr_reg <= port_addr;
      if (port_addr != addr_reg || port_cs_n || port_rd_n)
        quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
        quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  tick_period_a:
    assert property (timer_tick && !chg |-> gap_reg == lim)
    else $error("tick spacing wrong");
  tick_overdue_a:
    assert property (!chg |-> gap_reg <= lim)
    else $error("tick overdue");
  tick_pulse_a:
    assert property (timer_tick |=> !timer_tick)
    else $error("tick longer than one cycle");
  irq_cause_a:
    assert property (timer_irq |-> $past(timer_tick))
    else $error("interrupt without tick");
  irq_pulse_a:
    assert property (timer_irq |=> !timer_irq)
    else $error("interrupt longer than one cycle");
  oe_on_a:
    assert property ((!port_cs_n && !port_rd_n) [*5] |-> port_data_oe)
    else $error("read not driven");
  oe_off_a:
    assert property (port_rd_n [*5] |-> !port_data_oe)
    else $error("driving without read");
  unmapped_zero_a:
    assert property (quiet_reg >= 4'h4 && port_data_oe && port_addr > 8'h05
      && port_addr != `MASK_TWO_OFS |-> port_data_out == `UNMAPPED_DATA)
    else $error("unmapped read not zero");
  cover property (timer_tick && !chg);
  cover property (timer_irq);
  cover property (quiet_reg == 4'h4 && port_addr > 8'h05
    && port_addr != `MASK_TWO_OFS);
endmodule // perf_chk

bind e1_performance_error_counters perf_chk #(
  .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)
) i_perf_chk (
  .mclk(mclk), .rst_n(rst_n), .period_short(period_short),
  .port_cs_n(port_cs_n), .port_rd_n(port_rd_n), .port_addr(port_addr),
  .port_data_out(port_data_out), .port_data_oe(port_data_oe),
  .timer_tick(timer_tick), .timer_irq(timer_irq));
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the performance counter block.
// Assumes: Short counts stand in for the one-second timer.
// Notes:   A behavioural model tallies events between ticks.
`timescale 1ns/1ps
`default_nettype none
`include "perf_defs.svh"
`define CHK(g, e) \
  begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import perf_pkg::*;
  localparam int unsigned LC = 66000;
  localparam int unsigned SC = 100;
  logic  mclk, rst_n, stb, pos, neg, aerr, cerr, estb, ev, fsl, msl, csl;
  logic  per, cvm, hdb, cs_n, rd_n, wr_n, oe, tick, irq, stim_on, sat;
  logic  [3:0] efr;
  logic  [31:0] r;
  byte_t addr, din, dout, mk;
  int    seed, mismatches, n_compared, i, zeros, ticks, irqs, t0, q0, iv;
  int    vr, cr, er, ar, vl, cl, el, al;
  bit    have_mark, last_pol, have_bpv, bpv_pol;
  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;
  e1_performance_error_counters #(.LONG_CYCLES(LC), .SHORT_CYCLES(SC))
    i_e1_performance_error_counters (
    .mclk(mclk), .rst_n(rst_n), .rx_bit_stb(stb), .rx_pos(pos),
    .rx_neg(neg), .align_word_err(aerr), .crc_word_err(cerr),
    .ebit_stb(estb), .ebit_frame(efr), .ebit_value(ev),
    .frame_sync_lost(fsl), .crc_mf_sync_lost(msl), .cas_mf_sync_lost(csl),
    .period_short(per), .code_viol_mode(cvm), .hdb3_enable(hdb),
    .port_cs_n(cs_n), .port_rd_n(rd_n), .port_wr_n(wr_n), .port_addr(addr),
    .port_data_in(din), .port_data_out(dout), .port_data_oe(oe),
    .timer_tick(tick), .timer_irq(irq));
  // Random line and framer events; sat sends marks of one polarity.
  always @(posedge mclk) begin
    r = $random(seed);
    if (stim_on) begin
      stb <= sat | r[0];
      pos <= sat | (r[1] & r[2]);
      neg <= !sat & r[1] & !r[2];
      {aerr, cerr, estb, ev} <= r[6:3];
      efr <= r[7] ? {2'b11, r[8], 1'b1} : r[12:9];
      fsl <= r[15:13] == 3'h0;
      msl <= r[18:16] == 3'h0;
      csl <= r[19];
    end
  end
  // Reference counts; inputs are seen as they stood before the edge.
  always @(posedge mclk) begin
    iv = 0;
    if (stb && (pos || neg)) begin
      if (have_mark && last_pol == pos) begin
        if (cvm)
          iv = have_bpv && bpv_pol == pos;
        else
          iv = !(hdb && (zeros == 2 || zeros == 3));
        have_bpv = 1;
        bpv_pol = pos;
      end
      have_mark = 1;
      last_pol = pos;
      zeros = 0;
    end else if (stb)
      zeros++;
    vr = (vr + iv > 65535) ? 65535 : vr + iv;
    cr += cerr && !fsl && !msl;
    er += estb && !ev && !fsl && !msl
      && (efr == `MF_FRAME_A || efr == `MF_FRAME_B);
    ar += aerr && !fsl;
    if (tick) begin
      vl = vr;
      cl = cr % 1024;
      el = er % 1024;
      al = ar % 4096;
      {vr, cr, er, ar} = '0;
      ticks++;
    end
    irqs += irq;
  end
  // Expected byte at an offset; unlisted offsets read as zero.
  function automatic byte_t exp_of(input byte_t a);
    case (a)
      `VIOL_HIGH_OFS: return vl[15:8];
      `VIOL_LOW_OFS:  return vl[7:0];
      `CRC_HIGH_OFS:  return {al[11:6], cl[9:8]};
      `CRC_LOW_OFS:   return cl[7:0];
      `FAR_HIGH_OFS:  return {al[5:0], el[9:8]};
      `FAR_LOW_OFS:   return el[7:0];
      `MASK_TWO_OFS:  return mk;
      default:        return `UNMAPPED_DATA;
    endcase
  endfunction
  // Read with strobes low for six edges, then high for three, so that
  // back-to-back reads keep the port's minimum spacing.
  task automatic rd(input byte_t a);
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(oe, 1'b1)
    `CHK(dout, exp_of(a))
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic idle();
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // Address and data stay put until the commit after wr_n rises.
  task automatic wr(input byte_t a, input byte_t d);
    addr <= a;
    din <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (5) @(posedge mclk);
    idle();
    if (a == `MASK_TWO_OFS)
      mk = d;
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (tick !== 1'b1 && n < LC + 64);
    if (tick !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence: reset, register checks, then one read-out per tick.
  initial begin
    seed = 32'h45b8;
    mclk = 1'b0;
    mk = `MASK_TWO_RST;
    {rst_n, stim_on, sat, stb, pos, neg, aerr, cerr, estb, ev} = '0;
    {fsl, msl, csl, cvm, hdb, efr, addr, din} = '0;
    {per, cs_n, rd_n, wr_n} = 4'hF;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    stim_on <= 1'b1;
    rd(`MASK_TWO_OFS);
    rd(8'h10);
    idle();
    wr(`VIOL_LOW_OFS, 8'hA5);
    for (i = 0; i < 16; i++) begin
      cvm <= i[1];
      hdb <= i[2];
      wait_tick();
      for (int a = 0; a < 6; a++) rd(a[7:0]);
      idle();
      if (i == 3 || i == 9) begin
        `CHK(irqs - q0, (i == 9) ? ticks - t0 : 0)
        wr(`MASK_TWO_OFS, (i == 3) ? 8'h10 : 8'hEF);
        t0 = ticks;
        q0 = irqs;
      end
      if (i == 12) begin
        rd(`MASK_TWO_OFS);
        idle();
        `CHK(irqs - q0, 0)
      end
      per <= (i != 13);
      sat <= (i == 13);
    end
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
